// ===== usb_stat_ctl_pkg.sv
/*
  Package for the USB status, control and endpoint-control register block:
  register addresses, field positions, reset values and record types.
  Assumes a single 25 MHz clock domain and a plain strobe register port.
*/
package usb_stat_ctl_pkg;

  // ==========================================================
  // Register map (byte addresses, word index = address / 4)
  // ==========================================================
  localparam logic [7:0] ADDR_STATUS = 8'h00; // last_transfer_status
  localparam logic [7:0] ADDR_CONTROL = 8'h04; // usb_module_control
  localparam logic [7:0] ADDR_EP_BASE = 8'h40; // endpoint_control 0..15
  localparam logic [7:0] ADDR_EP_LAST = 8'h7c; // endpoint_control 15

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int STAT_EP_LSB = 4; // Endpoint number, bits 7..4
  localparam int STAT_DIR_BIT = 3; // Direction
  localparam int STAT_BANK_BIT = 2; // Ping-pong bank
  localparam int CON_JLEVEL_BIT = 7;
  localparam int CON_SE0_BIT = 6;
  localparam int CON_PACKET_PROCESSING_DISABLE_BIT = 5; // Also token in progress in host mode
  localparam int CON_BUSRST_BIT = 4;
  localparam int CON_HOST_FUNCTION_ENABLE_BIT = 3;
  localparam int CON_RESUME_BIT = 2;
  localparam int CON_PPRST_BIT = 1;
  localparam int CON_USBEN_BIT = 0;
  localparam int EP_LOW_SPEED_DIRECT_BIT = 7;
  localparam int EP_RETRY_BIT = 6;
  localparam int EP_CONDIS_BIT = 4;
  localparam int EP_RXEN_BIT = 3;
  localparam int EP_TXEN_BIT = 2;
  localparam int EP_STALL_BIT = 1;
  localparam int EP_HSHK_BIT = 0;

  // ==========================================================
  // Reset values and sizes
  // ==========================================================
  localparam logic [7:0] CON_RESET = 8'h00;
  localparam logic [7:0] EP_RESET = 8'h00;
  localparam logic [7:0] EP_WMASK = 8'hdf; // Bit 5 unimplemented
  localparam logic [5:0] CON_WMASK = 6'h3f; // Bits 5..0 writable
  localparam int FIFO_DEPTH = 4;
  localparam int NUM_EP = 16;

  // ==========================================================
  // Carrier types
  // ==========================================================
  // One completed-transaction record from the packet engine
  typedef struct packed {
    logic [3:0] endpoint; // Endpoint whose descriptor was updated
    logic txDir; // 1 transmit, 0 receive
    logic oddBank; // 1 odd bank, 0 even bank
  } xfer_rec_t;

  // Per-endpoint decoded policy for the packet engine
  typedef struct packed {
    logic rxEn;
    logic txEn;
    logic setupOk; // Control (SETUP) transfers permitted
    logic handshake;
    logic stalled;
  } ep_policy_t;

endpackage : usb_stat_ctl_pkg

// ===== usb_stat_ctl.sv
/*
  USB status queue, module control register and sixteen endpoint-control
  registers. Assumes the packet engine supplies transaction records, the
  transfer-done flag pop and live line levels, all synchronous to mclk.
*/
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module usb_stat_ctl
  import usb_stat_ctl_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH // Status queue depth
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clkEn,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  // Packet engine events
  input wire logic recPush, // Completed transaction
  input wire xfer_rec_t recIn,
  input wire logic doneFlagClear, // transfer_done_flag cleared
  input wire logic setupSeen, // SETUP token received
  input wire logic tokenActive, // Host token executing
  input wire logic stallEvent, // Endpoint stalled
  input wire logic [3:0] stallEp,
  // Live line levels
  input wire logic lineJ,
  input wire logic lineSe0,
  // Controls toward the packet engine
  output logic statusValid,
  output logic recDrop, // Record arrived with queue full and no pop
  output logic packetProcessingDisable,
  output logic busResetDrive,
  output logic hostFunctionEnable,
  output logic hostLogicReset,
  output logic resumeDrive,
  output logic lsEopAppend,
  output logic pingpongReset,
  output logic moduleEnable,
  output logic lowSpeedDirect,
  output logic nakRetryDisable,
  output ep_policy_t [NUM_EP-1:0] epPolicy
);

  // ==========================================================
  // Local state
  // ==========================================================
  localparam int PW = $clog2(DEPTH);
  xfer_rec_t fifoMem [DEPTH]; // Record queue storage
  logic [PW-1:0] rdPtr_q, wrPtr_q; // Queue pointers
  logic [PW:0] count_q; // Entries held
  logic [5:0] con_q; // Writable control bits 5..0
  logic [7:0] ep_q [NUM_EP]; // Endpoint control registers
  logic hostEnPrev_q; // For toggle detection
  logic resumePrev_q; // For resume fall detection
  logic wrCon, wrEp, doPush, doPop;
  logic [3:0] epIdx;

  // Address decode, used for both read and write paths
  function automatic logic isEp(input logic [7:0] a);
    isEp = (a >= ADDR_EP_BASE) && (a <= ADDR_EP_LAST) && (a[1:0] == 2'b00);
  endfunction : isEp

  assign epIdx = regAddr[5:2];
  assign wrCon = regWr && (regAddr == ADDR_CONTROL);
  assign wrEp = regWr && isEp(regAddr);
  // Pop only while something is held; push when room, or when popping
  assign doPop = doneFlagClear && (count_q != '0);
  assign doPush = recPush && ((count_q != (PW+1)'(DEPTH)) || doPop);

  // ==========================================================
  // Status record queue
  // ==========================================================
  // Queue pointers and occupancy
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rdPtr_q <= '0;
      wrPtr_q <= '0;
      count_q <= '0;
    end else if (clkEn) begin
      if (doPush) begin
        wrPtr_q <= wrPtr_q + PW'(1);
      end
      if (doPop) begin
        rdPtr_q <= rdPtr_q + PW'(1);
      end
      count_q <= count_q + (PW+1)'(doPush) - (PW+1)'(doPop);
    end
  end

  // Storage written only; no reset needed on data
  always_ff @(posedge mclk) begin
    if (clkEn && doPush) begin
      fifoMem[wrPtr_q] <= recIn;
    end
  end

  // Status valid while something sits at the head
  assign statusValid = (count_q != '0);
  // A lost record is flagged; the engine should hold off instead
  assign recDrop = recPush && !doPush;

  // ==========================================================
  // Module control register
  // ==========================================================
  // Bits 5..0; bits 7,6 are live and never stored
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      con_q <= CON_RESET[5:0];
    end else if (clkEn) begin
      if (wrCon) begin
        con_q <= regWrData[5:0] & CON_WMASK;
      end
      // SETUP set wins over a software clear in the same cycle
      if (setupSeen && !con_q[CON_HOST_FUNCTION_ENABLE_BIT]) begin
        con_q[CON_PACKET_PROCESSING_DISABLE_BIT] <= 1'b1;
      end
    end
  end

  // Edge history for host enable and resume
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      hostEnPrev_q <= 1'b0;
      resumePrev_q <= 1'b0;
    end else if (clkEn) begin
      hostEnPrev_q <= con_q[CON_HOST_FUNCTION_ENABLE_BIT];
      resumePrev_q <= con_q[CON_RESUME_BIT];
    end
  end

  // Control outputs
  assign hostFunctionEnable = con_q[CON_HOST_FUNCTION_ENABLE_BIT];
  assign hostLogicReset = hostEnPrev_q ^ con_q[CON_HOST_FUNCTION_ENABLE_BIT];
  // Device mode only; in host mode bit 5 is a busy indicator
  assign packetProcessingDisable = !con_q[CON_HOST_FUNCTION_ENABLE_BIT] && con_q[CON_PACKET_PROCESSING_DISABLE_BIT];
  assign busResetDrive = con_q[CON_HOST_FUNCTION_ENABLE_BIT] && con_q[CON_BUSRST_BIT];
  assign resumeDrive = con_q[CON_RESUME_BIT];
  // One-cycle request to append a low-speed EOP after resume ends
  assign lsEopAppend = con_q[CON_HOST_FUNCTION_ENABLE_BIT] && resumePrev_q
                       && !con_q[CON_RESUME_BIT];
  assign pingpongReset = con_q[CON_PPRST_BIT];
  assign moduleEnable = con_q[CON_USBEN_BIT];

  // ==========================================================
  // Endpoint control registers
  // ==========================================================
  generate
    for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
      // Software write, hardware stall set wins over write
      always_ff @(posedge mclk) begin
        if (!resetn) begin
          ep_q[e] <= EP_RESET;
        end else if (clkEn) begin
          if (wrEp && (epIdx == 4'(e))) begin
            ep_q[e] <= regWrData[7:0] & EP_WMASK;
          end
          if (stallEvent && (stallEp == 4'(e))) begin
            ep_q[e][EP_STALL_BIT] <= 1'b1;
          end
        end
      end
      // Decoded policy toward the packet engine
      assign epPolicy[e].rxEn = ep_q[e][EP_RXEN_BIT];
      assign epPolicy[e].txEn = ep_q[e][EP_TXEN_BIT];
      // Condis only counts when both directions are on
      assign epPolicy[e].setupOk = ep_q[e][EP_RXEN_BIT] && ep_q[e][EP_TXEN_BIT]
                                   && !ep_q[e][EP_CONDIS_BIT];
      assign epPolicy[e].handshake = ep_q[e][EP_HSHK_BIT];
      assign epPolicy[e].stalled = ep_q[e][EP_STALL_BIT];
    end
  endgenerate

  // Endpoint 0 host-only controls
  assign lowSpeedDirect = con_q[CON_HOST_FUNCTION_ENABLE_BIT] && ep_q[0][EP_LOW_SPEED_DIRECT_BIT];
  assign nakRetryDisable = con_q[CON_HOST_FUNCTION_ENABLE_BIT] && ep_q[0][EP_RETRY_BIT];

  // ==========================================================
  // Read path
  // ==========================================================
  // Registered read data, valid the cycle after the strobe only
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      regRdData <= '0;
    end else if (clkEn) begin
      regRdData <= '0;
      if (regRd) begin
        if (regAddr == ADDR_STATUS) begin
          // Head record; meaningless when queue is empty
          regRdData[7:2] <= {fifoMem[rdPtr_q].endpoint, fifoMem[rdPtr_q].txDir,
                             fifoMem[rdPtr_q].oddBank};
        end else if (regAddr == ADDR_CONTROL) begin
          regRdData[CON_JLEVEL_BIT] <= lineJ;
          regRdData[CON_SE0_BIT] <= lineSe0;
          // Busy indicator in host mode, software must poll it
          regRdData[CON_PACKET_PROCESSING_DISABLE_BIT] <= con_q[CON_HOST_FUNCTION_ENABLE_BIT] ? tokenActive
                                       : con_q[CON_PACKET_PROCESSING_DISABLE_BIT];
          regRdData[4:0] <= con_q[4:0];
        end else if (isEp(regAddr)) begin
          regRdData[7:0] <= ep_q[epIdx];
        end
      end
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  sequence s_ctlWrite; regWr && (regAddr == ADDR_CONTROL) && clkEn; endsequence
  sequence s_ctlRead; regRd && (regAddr == ADDR_CONTROL) && clkEn; endsequence
  sequence s_ep0Write; regWr && (regAddr == ADDR_EP_BASE) && clkEn; endsequence
  property p_popOnClear;
    @(posedge mclk) disable iff (!resetn)
      (clkEn && doneFlagClear && statusValid && !recPush) |=> (count_q == $past(count_q) - 1'b1);
  endproperty
  a_popOnClear: assert property (p_popOnClear) else $error("queue did not pop");
  property p_setupSets;
    @(posedge mclk) disable iff (!resetn)
      (clkEn && setupSeen && !hostFunctionEnable) |=> packetProcessingDisable;
  endproperty
  a_setupSets: assert property (p_setupSets) else $error("setup did not disable");
  property p_hostToggle;
    @(posedge mclk) disable iff (!resetn)
      (clkEn && $changed(hostFunctionEnable)) |-> hostLogicReset;
  endproperty
  a_hostToggle: assert property (p_hostToggle) else $error("no host reset on toggle");
  property p_resume;
    @(posedge mclk) disable iff (!resetn)
      s_ctlWrite ##1 clkEn |-> (resumeDrive == $past(regWrData[CON_RESUME_BIT]));
  endproperty
  a_resume: assert property (p_resume) else $error("resume not following write");
  property p_busReset;
    @(posedge mclk) disable iff (!resetn)
      s_ctlWrite |=> (busResetDrive == ($past(regWrData[CON_HOST_FUNCTION_ENABLE_BIT])
                                        && $past(regWrData[CON_BUSRST_BIT])));
  endproperty
  a_busReset: assert property (p_busReset) else $error("bus reset outside host");
  property p_eop;
    @(posedge mclk) disable iff (!resetn)
      (hostFunctionEnable && $fell(resumeDrive)) |-> lsEopAppend;
  endproperty
  a_eop: assert property (p_eop) else $error("bad eop request");
  property p_setupOk;
    @(posedge mclk) disable iff (!resetn)
      s_ep0Write |=> (epPolicy[0].setupOk == ($past(regWrData[EP_RXEN_BIT])
                      && $past(regWrData[EP_TXEN_BIT]) && !$past(regWrData[EP_CONDIS_BIT])));
  endproperty
  a_setupOk: assert property (p_setupOk) else $error("setup allowed one-way");
  property p_upperZero;
    @(posedge mclk) disable iff (!resetn)
      regRdData[31:8] == 24'h000000;
  endproperty
  a_upperZero: assert property (p_upperZero) else $error("upper bits nonzero");
  property p_stall;
    @(posedge mclk) disable iff (!resetn)
      (clkEn && stallEvent && stallEp == 4'h0) |=> epPolicy[0].stalled;
  endproperty
  a_stall: assert property (p_stall) else $error("stall not recorded");

  // A record into an empty queue shows on the next cycle
  property p_pushShows;
    @(posedge mclk) disable iff (!resetn)
      (clkEn && recPush && !statusValid) |=> statusValid;
  endproperty
  a_pushShows: assert property (p_pushShows) else $error("pushed record not shown");

  // A refused record leaves the occupancy alone
  property p_dropHolds;
    @(posedge mclk) disable iff (!resetn)
      (clkEn && recDrop) |=> (count_q == $past(count_q));
  endproperty
  a_dropHolds: assert property (p_dropHolds) else $error("refused record counted");

  // Never more records held than the queue has room for
  property p_fullCap;
    @(posedge mclk) disable iff (!resetn)
      count_q <= (PW+1)'(DEPTH);
  endproperty
  a_fullCap: assert property (p_fullCap) else $error("queue overfilled");

  // Popping the last record drops the valid indication
  property p_lastPop;
    @(posedge mclk) disable iff (!resetn)
      (clkEn && doneFlagClear && (count_q == (PW+1)'(1)) && !recPush) |=> !statusValid;
  endproperty
  a_lastPop: assert property (p_lastPop) else $error("valid after last pop");

  // Idle cycles return zero read data, so stale words never linger
  property p_rdIdle;
    @(posedge mclk) disable iff (!resetn)
      (clkEn && !regRd) |=> (regRdData == 32'h0);
  endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data not cleared");

  // Live line flags read as sampled
  property p_liveRead;
    @(posedge mclk) disable iff (!resetn)
      s_ctlRead |=> (regRdData[7:6] == $past({lineJ, lineSe0}));
  endproperty
  a_liveRead: assert property (p_liveRead) else $error("live flags wrong");

  // Host mode: bit 5 reads the token busy level
  property p_tokenRead;
    @(posedge mclk) disable iff (!resetn)
      (s_ctlRead ##0 hostFunctionEnable) |=> (regRdData[CON_PACKET_PROCESSING_DISABLE_BIT] == $past(tokenActive));
  endproperty
  a_tokenRead: assert property (p_tokenRead) else $error("token busy not read");

  // Device mode: bit 5 reads the processing disable
  property p_deviceBusy;
    @(posedge mclk) disable iff (!resetn)
      (s_ctlRead ##0 !hostFunctionEnable) |=> (regRdData[CON_PACKET_PROCESSING_DISABLE_BIT]
                                               == $past(packetProcessingDisable));
  endproperty
  a_deviceBusy: assert property (p_deviceBusy) else $error("disable bit not read");

  // Status writes touch no queue state
  property p_statusWrite;
    @(posedge mclk) disable iff (!resetn)
      (clkEn && regWr && (regAddr == ADDR_STATUS) && !recPush && !doneFlagClear)
        |=> ($stable(count_q) && $stable(rdPtr_q));
  endproperty
  a_statusWrite: assert property (p_statusWrite) else $error("status write took effect");

  // End-of-packet request lasts one enabled cycle
  property p_eopOnce;
    @(posedge mclk) disable iff (!resetn)
      (clkEn && lsEopAppend) |=> !lsEopAppend;
  endproperty
  a_eopOnce: assert property (p_eopOnce) else $error("eop request too long");

  // Host logic reset only follows a control write
  property p_hostQuiet;
    @(posedge mclk) disable iff (!resetn)
      (clkEn && !wrCon) |=> !hostLogicReset;
  endproperty
  a_hostQuiet: assert property (p_hostQuiet) else $error("spurious host reset");

  // Resume signalling moves only on a control write
  property p_resumeHold;
    @(posedge mclk) disable iff (!resetn)
      (clkEn && !wrCon) |=> $stable(resumeDrive);
  endproperty
  a_resumeHold: assert property (p_resumeHold) else $error("resume moved alone");

  // Endpoint 0 direction enables follow the write
  property p_epWrite;
    @(posedge mclk) disable iff (!resetn)
      s_ep0Write |=> ((epPolicy[0].rxEn == $past(regWrData[EP_RXEN_BIT]))
                      && (epPolicy[0].txEn == $past(regWrData[EP_TXEN_BIT])));
  endproperty
  a_epWrite: assert property (p_epWrite) else $error("direction enables wrong");

endmodule : usb_stat_ctl

`default_nettype wire

// ===== usb_far_model.sv
/*
  Far-side model: packet engine and USB line levels feeding the block.
  Assumes mclk from the bench; every change follows a rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
module usb_far_model
  import usb_stat_ctl_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Toward the block
  output logic recPush,
  output xfer_rec_t recIn,
  output logic setupSeen,
  output logic tokenActive,
  output logic lineJ,
  output logic lineSe0
);
  // ==========================================
  // Idle levels
  // ==========================================
  initial begin
    recPush = 1'b0;
    recIn = '0;
    setupSeen = 1'b0;
    tokenActive = 1'b0;
    lineJ = 1'b1; // Idle full-speed bus rests in J
    lineSe0 = 1'b0;
  end
  // One finished transaction; record is not held afterwards
  task automatic push(input xfer_rec_t r);
    @(posedge mclk);
    recPush <= 1'b1;
    recIn <= r;
    @(posedge mclk);
    recPush <= 1'b0;
    recIn <= ~r;
  endtask : push
  // SETUP token seen, one cycle
  task automatic setup_token();
    @(posedge mclk);
    setupSeen <= 1'b1;
    @(posedge mclk);
    setupSeen <= 1'b0;
  endtask : setup_token
  // Host token busy level
  task automatic token(input logic b);
    @(posedge mclk);
    tokenActive <= b;
  endtask : token
  // Live line levels
  task automatic lines(input logic j, input logic s);
    @(posedge mclk);
    lineJ <= j;
    lineSe0 <= s;
  endtask : lines
endmodule : usb_far_model
`default_nettype wire

// ===== testbench.sv
/*
  Self-checking bench for the status queue, control and endpoint registers.
  Assumes the far-side model file is compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import usb_stat_ctl_pkg::*;
  // ==========================================
  // Signals
  // ==========================================
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic clkEn = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic doneFlagClear = 1'b0;
  logic stallEvent = 1'b0;
  logic [3:0] stallEp = 4'h0;
  logic [31:0] regRdData;
  logic recPush, setupSeen, tokenActive, lineJ, lineSe0;
  xfer_rec_t recIn;
  logic statusValid, recDrop, packetProcessingDisable, busResetDrive;
  logic hostFunctionEnable, hostLogicReset, resumeDrive, lsEopAppend;
  logic pingpongReset, moduleEnable, lowSpeedDirect, nakRetryDisable;
  ep_policy_t [NUM_EP-1:0] epPolicy;
  logic [31:0] seed = 32'h24; // Fixed start for repeatable runs
  logic [31:0] expQ[$]; // Expected read words, oldest first
  logic rdLate = 1'b0;
  logic dropExp = 1'b0;
  int fails = 0;
  int nTests = 0;
  int hlrN = 0;
  int eopN = 0;
  // Far shorter than a real wake-up hold, which would swamp the run
  localparam int RESUME_HOLD = 50;
  always #20 mclk = ~mclk; // 25 MHz
  usb_stat_ctl usb_stat_ctl_inst (.mclk(mclk), .resetn(resetn), .clkEn(clkEn),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .recPush(recPush), .recIn(recIn),
    .doneFlagClear(doneFlagClear), .setupSeen(setupSeen), .tokenActive(tokenActive),
    .stallEvent(stallEvent), .stallEp(stallEp), .lineJ(lineJ), .lineSe0(lineSe0),
    .statusValid(statusValid), .recDrop(recDrop),
    .packetProcessingDisable(packetProcessingDisable), .busResetDrive(busResetDrive),
    .hostFunctionEnable(hostFunctionEnable), .hostLogicReset(hostLogicReset),
    .resumeDrive(resumeDrive), .lsEopAppend(lsEopAppend), .pingpongReset(pingpongReset),
    .moduleEnable(moduleEnable), .lowSpeedDirect(lowSpeedDirect),
    .nakRetryDisable(nakRetryDisable), .epPolicy(epPolicy));
  usb_far_model usb_far_model_inst (.mclk(mclk), .recPush(recPush), .recIn(recIn),
    .setupSeen(setupSeen), .tokenActive(tokenActive), .lineJ(lineJ), .lineSe0(lineSe0));
  // ==========================================
  // Helpers
  // ==========================================
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
    nTests++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t read %h exp %h", $time, g, e);
    end
  endtask : cmp32
  task automatic cmp1(input logic g, input logic e);
    nTests++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t flag %b exp %b", $time, g, e);
    end
  endtask : cmp1
  // Upper write bits random: they must never stick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] t;
    t = xs();
    @(posedge mclk);
    regAddr <= a;
    regWrData <= {t[31:8], d};
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    expQ.push_back({24'h0, e});
    @(posedge mclk);
    regRd <= 1'b0;
  endtask : rd
  task automatic pulse_count();
    hlrN = 0;
    eopN = 0;
    repeat (3) @(negedge mclk);
  endtask : pulse_count
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop
  // ==========================================
  // Watchers: read data one cycle late, drop, pulses
  // ==========================================
  always @(posedge mclk) rdLate <= regRd & clkEn;
  always @(negedge mclk) begin
    if (rdLate) cmp32(regRdData, expQ.pop_front());
    if (recPush) cmp1(recDrop, dropExp);
    hlrN += (hostLogicReset === 1'b1);
    eopN += (lsEopAppend === 1'b1);
  end
  // Hang guard
  initial begin
    repeat (5000) @(posedge mclk);
    fails++;
    report_and_stop();
  end
  // ==========================================
  // Main sequence
  // ==========================================
  initial begin
    xfer_rec_t mq[$];
    logic [31:0] t;
    logic [7:0] d;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    rd(ADDR_CONTROL, 8'h80);
    rd(8'h08, 8'h00);
    rd(ADDR_EP_BASE, EP_RESET);
    // Four records fit, the fifth is refused
    for (int i = 0; i < 5; i++) begin
      t = xs();
      dropExp = (i == 4);
      if (i < 4) mq.push_back(t[5:0]);
      usb_far_model_inst.push(t[5:0]);
    end
    wr(ADDR_STATUS, 8'hff);
    for (int i = 0; i < 4; i++) begin
      rd(ADDR_STATUS, {mq[0], 2'b00});
      cmp1(statusValid, 1'b1);
      @(posedge mclk);
      doneFlagClear <= 1'b1;
      @(posedge mclk);
      doneFlagClear <= 1'b0;
      void'(mq.pop_front());
    end
    #1 cmp1(statusValid, 1'b0);
    // Device mode control, live flags not writable
    usb_far_model_inst.lines(1'b0, 1'b1);
    wr(ADDR_CONTROL, 8'hf7);
    rd(ADDR_CONTROL, 8'h77);
    cmp1(pingpongReset & moduleEnable, 1'b1);
    cmp1(resumeDrive, 1'b1);
    cmp1(busResetDrive, 1'b0);
    wr(ADDR_CONTROL, 8'h00);
    cmp1(resumeDrive, 1'b0);
    usb_far_model_inst.setup_token();
    #1 cmp1(packetProcessingDisable, 1'b1);
    rd(ADDR_CONTROL, 8'h60);
    // Host mode entry, token busy, bus reset
    wr(ADDR_CONTROL, 8'h18);
    pulse_count();
    cmp1(hlrN == 1, 1'b1);
    cmp1(hostFunctionEnable, 1'b1);
    cmp1(busResetDrive, 1'b1);
    usb_far_model_inst.token(1'b1);
    rd(ADDR_CONTROL, 8'h78);
    usb_far_model_inst.token(1'b0);
    rd(ADDR_CONTROL, 8'h58);
    wr(ADDR_CONTROL, 8'h0c);
    repeat (RESUME_HOLD) @(posedge mclk);
    cmp1(resumeDrive, 1'b1);
    wr(ADDR_CONTROL, 8'h08);
    pulse_count();
    cmp1(eopN == 1 && hlrN == 0, 1'b1);
    // Every endpoint register, random contents
    for (int n = 0; n < NUM_EP; n++) begin
      t = xs();
      d = t[7:0];
      if (n == 0) d[3:2] = 2'b11;
      wr(ADDR_EP_BASE + 8'(n * 4), d);
      rd(ADDR_EP_BASE + 8'(n * 4), d & EP_WMASK);
      cmp1(epPolicy[n].rxEn, d[3]);
      cmp1(epPolicy[n].txEn, d[2]);
      cmp1(epPolicy[n].stalled, d[1]);
      cmp1(epPolicy[n].handshake, d[0]);
      if (d[3] & d[2]) cmp1(epPolicy[n].setupOk, ~d[4]);
      else cmp1(epPolicy[n].setupOk, 1'b0);
      if (n == 0) cmp1(lowSpeedDirect, d[7]);
      if (n == 0) cmp1(nakRetryDisable, d[6]);
    end
    // Stall endpoint 0, then endpoint 5
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_EP_BASE + 8'(k * 20), 8'h00);
      @(posedge mclk);
      stallEp <= 4'(k * 5);
      stallEvent <= 1'b1;
      @(posedge mclk);
      stallEvent <= 1'b0;
      #1 cmp1(epPolicy[k * 5].stalled, 1'b1);
    end
    // Leaving host mode resets host logic and gates host outputs
    wr(ADDR_CONTROL, 8'h00);
    pulse_count();
    cmp1(hlrN == 1, 1'b1);
    cmp1(lowSpeedDirect | nakRetryDisable, 1'b0);
    // Frozen clock enable ignores a write
    @(posedge mclk);
    clkEn <= 1'b0;
    wr(ADDR_CONTROL, 8'h04);
    @(posedge mclk);
    clkEn <= 1'b1;
    cmp1(resumeDrive, 1'b0);
    repeat (2) @(posedge mclk);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
